// >>> hdl/virtual_com_uart_bridge.sv
// Serial bridge between host byte streams and the target's UART pins
`timescale 1ns/10ps
module virtual_com_uart_bridge (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_load,
  input  wire logic [15:0] cfg_baud_div,
  input  wire logic [1:0]  cfg_hs_mode,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic             rx_dropped,
  input  wire logic        vcom_enable,
  input  wire logic        target_tx_line,
  output logic             target_rx_line,
  input  wire logic        target_rts_n,
  output logic             target_cts_n_o,
  output logic             target_cts_n_oe
);
  stream_if rx_fill ();
  stream_if rx_drain ();

  // Configuration state
  logic [15:0]                div_q, div_d;
  vcom_pkg::hs_mode_type      mode_q, mode_d;

  always_comb begin
    div_d  = div_q;
    mode_d = mode_q;
    if (cfg_load) begin
      mode_d = vcom_pkg::hs_mode_type'(cfg_hs_mode);
      if (cfg_baud_div < vcom_pkg::DIV_MIN) div_d = vcom_pkg::DIV_MIN;
      else if (cfg_baud_div > vcom_pkg::DIV_MAX) div_d = vcom_pkg::DIV_MAX;
      else div_d = cfg_baud_div;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_q  <= vcom_pkg::DIV_RESET;
      mode_q <= vcom_pkg::HS_DISABLED;
    end else begin
      div_q  <= div_d;
      mode_q <= mode_d;
    end
  end

  // Three-stage synchronisers; value moves when stages two and three agree
  logic [2:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  always_comb begin
    flt_d = flt_q;
    for (int i = 0; i < 3; i++) begin
      if (s2_q[i] == s3_q[i]) flt_d[i] = s3_q[i];
    end
  end

  always_ff @(posedge core_clk) begin
    s1_q <= {vcom_enable, target_rts_n, target_tx_line};
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (!rst_n) flt_q <= 3'h3;
    else flt_q <= flt_d;
  end

  logic line_in, rts_asserted, enabled, tx_gate, cts_drive;
  always_comb begin
    line_in      = flt_q[0];
    rts_asserted = !flt_q[1];
    enabled      = flt_q[2];
    cts_drive    = (mode_q == vcom_pkg::HS_RTS)
                   || (mode_q == vcom_pkg::HS_RTSCTS);
    tx_gate      = enabled
                   && (rts_asserted
                       || mode_q == vcom_pkg::HS_DISABLED
                       || mode_q == vcom_pkg::HS_RTS);
  end

  // Transmitter toward the target
  logic [9:0]  tsh_q, tsh_d;
  logic [3:0]  tbits_q, tbits_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic        tbusy_q, tbusy_d, tready_q, tready_d, tline_q, tline_d;

  always_comb begin
    tsh_d   = tsh_q;
    tbits_d = tbits_q;
    tcnt_d  = tcnt_q;
    tbusy_d = tbusy_q;
    tline_d = tline_q;
    if (!tbusy_q) begin
      tline_d = 1'b1;
      if (tx_valid && tready_q) begin
        tsh_d   = {1'b1, tx_data, 1'b0};
        tbits_d = vcom_pkg::FRAME_BITS;
        tcnt_d  = 16'h0000;
        tbusy_d = 1'b1;
      end
    end else if (tcnt_q == 16'h0000) begin
      // Runs to the stop bit whatever request-to-send does
      if (tbits_q == 4'h0) begin
        tbusy_d = 1'b0;
        tline_d = 1'b1;
      end else begin
        tline_d = tsh_q[0];
        tsh_d   = {1'b1, tsh_q[9:1]};
        tbits_d = 4'(tbits_q - 4'h1);
        tcnt_d  = 16'(div_q - 16'h0001);
      end
    end else begin
      tcnt_d = 16'(tcnt_q - 16'h0001);
    end
    tready_d = !tbusy_d && tx_gate;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tsh_q    <= 10'h3ff;
      tbits_q  <= 4'h0;
      tcnt_q   <= 16'h0000;
      tbusy_q  <= 1'b0;
      tready_q <= 1'b0;
      tline_q  <= 1'b1;
    end else begin
      tsh_q    <= tsh_d;
      tbits_q  <= tbits_d;
      tcnt_q   <= tcnt_d;
      tbusy_q  <= tbusy_d;
      tready_q <= tready_d;
      tline_q  <= tline_d;
    end
  end

  // Receiver from the target
  vcom_pkg::rx_state_type rst_q, rst_d;
  logic [7:0]  rsh_q, rsh_d;
  logic [3:0]  rbit_q, rbit_d;
  logic [15:0] rcnt_q, rcnt_d;
  logic        push_q, push_d, drop_q, drop_d;

  always_comb begin
    rst_d  = rst_q;
    rsh_d  = rsh_q;
    rbit_d = rbit_q;
    rcnt_d = (rcnt_q == 16'h0000) ? 16'h0000 : 16'(rcnt_q - 16'h0001);
    push_d = push_q && !rx_fill.ready;
    drop_d = 1'b0;
    unique case (rst_q)
      vcom_pkg::RX_IDLE: begin
        if (!line_in) begin
          rst_d  = vcom_pkg::RX_START;
          rcnt_d = {1'b0, div_q[15:1]}; // Sample at mid bit
        end
      end
      vcom_pkg::RX_START: begin
        if (rcnt_q == 16'h0000) begin
          rst_d  = line_in ? vcom_pkg::RX_IDLE : vcom_pkg::RX_DATA;
          rbit_d = 4'h0;
          rcnt_d = 16'(div_q - 16'h0001);
        end
      end
      vcom_pkg::RX_DATA: begin
        if (rcnt_q == 16'h0000) begin
          rsh_d  = {line_in, rsh_q[7:1]};
          rcnt_d = 16'(div_q - 16'h0001);
          rbit_d = 4'(rbit_q + 4'h1);
          if (rbit_q == vcom_pkg::DATA_LAST) rst_d = vcom_pkg::RX_STOP;
        end
      end
      vcom_pkg::RX_STOP: begin
        if (rcnt_q == 16'h0000) begin
          rst_d = vcom_pkg::RX_IDLE;
          if (line_in && enabled) begin
            if (push_q && !rx_fill.ready) drop_d = 1'b1;
            else push_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rst_q  <= vcom_pkg::RX_IDLE;
      rsh_q  <= 8'h00;
      rbit_q <= 4'h0;
      rcnt_q <= 16'h0000;
      push_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      rst_q  <= rst_d;
      rsh_q  <= rsh_d;
      rbit_q <= rbit_d;
      rcnt_q <= rcnt_d;
      push_q <= push_d;
      drop_q <= drop_d;
    end
  end

  // A held byte waits in the pending slot until the buffer takes it
  logic [7:0] pend_q, pend_d;
  always_comb begin
    pend_d = pend_q;
    // Any good frame not dropped, also while the older byte leaves this cycle
    if (rst_q == vcom_pkg::RX_STOP && rst_d == vcom_pkg::RX_IDLE && line_in && enabled
        && !drop_d) begin
      pend_d = rsh_q;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) pend_q <= 8'h00;
    else pend_q <= pend_d;
  end

  assign rx_fill.data  = pend_q;
  assign rx_fill.valid = push_q;

  byte_buffer u_rx_buffer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .fill     (rx_fill),
    .drain    (rx_drain)
  );

  assign rx_drain.ready = rx_ready;

  // Clear-to-send: low (asserted) while the buffer has room and no byte is pending
  logic cts_n_q, cts_n_d, cts_oe_q, cts_oe_d;
  always_comb begin
    cts_oe_d = cts_drive;
    cts_n_d  = !(rx_fill.ready && !push_q);
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cts_n_q  <= 1'b1;
      cts_oe_q <= 1'b0;
    end else begin
      cts_n_q  <= cts_n_d;
      cts_oe_q <= cts_oe_d;
    end
  end

  assign tx_ready        = tready_q;
  assign target_rx_line  = tline_q;
  assign rx_data         = rx_drain.data;
  assign rx_valid        = rx_drain.valid;
  assign rx_dropped      = drop_q;
  assign target_cts_n_o  = cts_n_q;
  assign target_cts_n_oe = cts_oe_q;
endmodule // virtual_com_uart_bridge

// >>> hdl/vcom_pkg.sv
// Constants and types shared by the serial bridge and its buffer
package vcom_pkg;
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned BAUD_RESET  = 115_200;
  localparam int unsigned BAUD_MIN    = 9_600;
  localparam int unsigned BAUD_MAX    = 921_600;
  localparam int          DIV_W       = 16;
  // Clock cycles per bit; slowest rate gives the largest divider
  localparam logic [15:0] DIV_RESET   = 16'(CLK_HZ / BAUD_RESET);
  localparam logic [15:0] DIV_MAX     = 16'(CLK_HZ / BAUD_MIN);
  localparam logic [15:0] DIV_MIN     = 16'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
  localparam int          DATA_W      = 8;
  localparam logic [3:0]  FRAME_BITS  = 4'ha;
  localparam logic [3:0]  DATA_LAST   = 4'h7;
  localparam int          BUF_DEPTH   = 2;

  typedef enum logic [1:0] {
    HS_DISABLED,
    HS_RTS,
    HS_CTS,
    HS_RTSCTS
  } hs_mode_type;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_type;
endpackage

// >>> hdl/stream_if.sv
// Valid/ready byte stream between the bridge and its buffer
`timescale 1ns/10ps
interface stream_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // stream_if

// >>> hdl/byte_buffer.sv
// Two-entry byte buffer with registered valid and ready
`timescale 1ns/10ps
module byte_buffer (
  input  wire logic core_clk,
  input  wire logic rst_n,
  stream_if.snk     fill,
  stream_if.src     drain
);
  logic [7:0] mem_q [vcom_pkg::BUF_DEPTH];
  logic [7:0] mem_d [vcom_pkg::BUF_DEPTH];
  logic       wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic       ready_q, valid_q;
  logic [7:0] head_q, head_d;
  logic       push, pop;

  // Next pointers, count and contents
  always_comb begin
    push  = fill.valid && ready_q;
    pop   = valid_q && drain.ready;
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = fill.data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    head_d = mem_d[rd_d]; // Oldest byte, registered for the output
  end

  // Register state
  always_ff @(posedge core_clk) begin
    mem_q  <= mem_d;
    head_q <= head_d;
    if (!rst_n) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      cnt_q   <= 2'h0;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      cnt_q   <= cnt_d;
      ready_q <= (cnt_d != 2'(vcom_pkg::BUF_DEPTH));
      valid_q <= (cnt_d != 2'h0);
    end
  end

  assign fill.ready  = ready_q;
  assign drain.valid = valid_q;
  assign drain.data  = head_q;
endmodule // byte_buffer

// >>> testbench/bridge_properties.sv
// Concurrent checks on the serial bridge ports
`timescale 1ns/10ps
module bridge_properties (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       cfg_load,
  input wire logic [1:0] cfg_hs_mode,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       rx_dropped,
  input wire logic       vcom_enable,
  input wire logic       target_rx_line,
  input wire logic       target_rts_n,
  input wire logic       target_cts_n_o,
  input wire logic       target_cts_n_oe
);
  logic [1:0] mode_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Handshake mode as last loaded
  always_ff @(posedge core_clk)
    if (!rst_n) mode_q <= 2'h0;
    else if (cfg_load) mode_q <= cfg_hs_mode;
  rst_idle_a: assert property (
      $rose(rst_n) |-> target_rx_line && !tx_ready && !target_cts_n_oe)
    else $error("bridge not idle after reset");
  cts_mode_a: assert property (
      !cfg_load && !$past(cfg_load) |-> target_cts_n_oe == mode_q[0])
    else $error("cts drive does not follow mode");
  rts_gate_a: assert property ((mode_q[1] && target_rts_n) [*8] |-> !tx_ready)
    else $error("ready while rts deasserted");
  en_gate_a: assert property ((!vcom_enable) [*8] |-> !tx_ready)
    else $error("ready while disabled");
  take_busy_a: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("second byte taken during frame");
  take_start_a: assert property (tx_valid && tx_ready |-> ##[1:2] !target_rx_line)
    else $error("no start bit after take");
  start_len_a: assert property ($fell(target_rx_line) |-> (!target_rx_line) [*8])
    else $error("start bit too short");
  ready_idle_a: assert property (tx_ready |-> target_rx_line)
    else $error("line not idle while ready");
  cts_full_a: assert property (target_cts_n_oe && target_cts_n_o |-> rx_valid)
    else $error("cts deasserted with no byte held");
  drop_cts_a: assert property (rx_dropped |-> target_cts_n_o)
    else $error("byte dropped while cts asserted");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received byte lost before pop");
endmodule // bridge_properties
bind virtual_com_uart_bridge bridge_properties bridge_properties_inst (.core_clk, .rst_n,
  .cfg_load, .cfg_hs_mode, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .rx_dropped,
  .vcom_enable, .target_rx_line, .target_rts_n, .target_cts_n_o, .target_cts_n_oe);

// >>> testbench/target_uart_model.sv
// Target UART with clear-to-send handshake
`timescale 1ns/10ps
module target_uart_model (
  input wire logic core_clk,
  input wire logic rx_line,
  input wire logic cts_n,
  output logic     tx_line
);
  logic [7:0] got;
  int         n_got;
  int         div;
  initial begin
    tx_line = 1'b1;
    got = 8'h00;
    n_got = 0;
    div = int'(vcom_pkg::DIV_RESET);
  end
  // Send one frame, held off while clear-to-send is deasserted
  task automatic send(input logic [7:0] b);
    do @(posedge core_clk); while (cts_n !== 1'b0);
    for (int i = 0; i < 10; i++) begin
      tx_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (div) @(posedge core_clk);
    end
  endtask
  // Decode frames towards the target at mid-bit
  initial forever begin
    @(negedge rx_line);
    repeat (div / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge core_clk);
      got[i] = rx_line;
    end
    repeat (div) @(posedge core_clk);
    if (rx_line === 1'b1) n_got++;
  end
endmodule // target_uart_model

// >>> testbench/testbench.sv
// Self-checking bench for the serial bridge
`timescale 1ns/10ps
module testbench;
  logic        core_clk, rst_n, cfg_load, tx_valid, tx_ready, rx_valid, rx_ready;
  logic        rx_dropped, vcom_enable, rts_n, tx_line, rx_line, cts_o, cts_oe;
  logic [15:0] cfg_baud_div;
  logic [1:0]  cfg_hs_mode;
  logic [7:0]  tx_data, rx_data;
  wire         cts_n = cts_oe ? cts_o : 1'b0; // Undriven leaves target free
  int          bad_count, n_checks, sent, n_drop;
  virtual_com_uart_bridge virtual_com_uart_bridge_inst (.core_clk, .rst_n, .cfg_load,
    .cfg_baud_div, .cfg_hs_mode, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_ready, .rx_dropped, .vcom_enable, .target_tx_line(tx_line),
    .target_rx_line(rx_line), .target_rts_n(rts_n), .target_cts_n_o(cts_o),
    .target_cts_n_oe(cts_oe));
  target_uart_model target_uart_model_inst (.core_clk, .rx_line, .cts_n, .tx_line);
  always #2.5 core_clk = ~core_clk;
  // Count lost-byte pulses from the bridge
  always @(posedge core_clk) begin
    if (rx_dropped === 1'b1) n_drop++;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cfg(input logic [1:0] m);
    @(posedge core_clk);
    cfg_hs_mode <= m;
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // Offer a byte and hold it until taken
  task automatic send(input logic [7:0] b);
    int t;
    t = 0;
    @(posedge core_clk);
    tx_data <= b;
    tx_valid <= 1'b1;
    do @(posedge core_clk); while (tx_ready !== 1'b1 && ++t < 9000);
    tx_valid <= 1'b0;
    chk("taken", 1, t < 9000);
  endtask
  // Await the next byte at the target
  task automatic got(input logic [7:0] b);
    int t;
    t = 0;
    sent++;
    while (target_uart_model_inst.n_got != sent && ++t < 20000) @(posedge core_clk);
    chk("target count", 16'(sent), 16'(target_uart_model_inst.n_got));
    chk("target byte", b, target_uart_model_inst.got);
  endtask
  task automatic pop(input logic [7:0] b);
    int t;
    t = 0;
    do @(posedge core_clk); while (rx_valid !== 1'b1 && ++t < 9000);
    chk("rx_valid", 1, rx_valid);
    chk("rx_data", b, rx_data);
    rx_ready <= 1'b1;
    @(posedge core_clk);
    rx_ready <= 1'b0;
  endtask
  task automatic s_reset();
    int n;
    n = 0;
    chk("line idle", 1, rx_line);
    chk("cts_oe", 0, cts_oe);
    send(8'h01);
    @(negedge rx_line);
    while (rx_line === 1'b0) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("start cycles", vcom_pkg::DIV_RESET, 16'(n));
    got(8'h01);
  endtask
  task automatic s_data();
    rts_n <= 1'b1;
    send(8'ha5);
    got(8'ha5);
    send(8'h3c);
    got(8'h3c);
    target_uart_model_inst.send(8'h5a);
    pop(8'h5a);
    vcom_enable <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("ready off", 0, tx_ready);
    target_uart_model_inst.send(8'h96);
    repeat (400) @(posedge core_clk);
    chk("rx_valid off", 0, rx_valid);
    vcom_enable <= 1'b1;
  endtask
  task automatic s_rts();
    rts_n <= 1'b0;
    cfg(2'h2);
    send(8'hc3);
    rts_n <= 1'b1;
    got(8'hc3);
    fork
      send(8'he7);
      begin
        repeat (3000) @(posedge core_clk);
        chk("held", 0, tx_ready);
        chk("target count", 16'(sent), 16'(target_uart_model_inst.n_got));
        rts_n <= 1'b0;
      end
    join
    got(8'he7);
  endtask
  task automatic s_cts();
    cfg(2'h1);
    target_uart_model_inst.send(8'h11);
    repeat (20) @(posedge core_clk);
    chk("cts_n one byte", 0, cts_o);
    target_uart_model_inst.send(8'h22);
    repeat (20) @(posedge core_clk);
    chk("cts_n full", 1, cts_o);
    fork
      target_uart_model_inst.send(8'h33);
      begin
        repeat (3000) @(posedge core_clk);
        chk("cts_n held", 1, cts_o);
        chk("no drop", 0, 16'(n_drop));
        pop(8'h11);
        pop(8'h22);
      end
    join
    pop(8'h33);
    repeat (5) @(posedge core_clk);
    chk("cts_n empty", 0, cts_o);
    for (int m = 0; m < 4; m++) begin
      cfg(2'(m));
      chk("cts_oe", 16'(m & 1), cts_oe);
    end
  endtask
  // Four frames with no pop: two buffered, one held, one lost
  task automatic s_drop();
    cfg(2'h0);
    target_uart_model_inst.send(8'h41);
    target_uart_model_inst.send(8'h42);
    target_uart_model_inst.send(8'h43);
    target_uart_model_inst.send(8'h44);
    repeat (20) @(posedge core_clk);
    chk("drop pulses", 1, 16'(n_drop));
    pop(8'h41);
    pop(8'h42);
    pop(8'h43);
    repeat (20) @(posedge core_clk);
    chk("rx_valid empty", 0, rx_valid);
  endtask
  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    cfg_load = 1'b0;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    rts_n = 1'b0;
    vcom_enable = 1'b1;
    cfg_baud_div = 16'h0001; // Below range, so clamped to the fastest rate
    cfg_hs_mode = 2'h0;
    tx_data = 8'h00;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    s_reset();
    target_uart_model_inst.div = int'(vcom_pkg::DIV_MIN);
    cfg(2'h0);
    s_data();
    s_rts();
    s_cts();
    s_drop();
    results();
  end
  // Watchdog against a hang
  initial begin
    #450000;
    bad_count++;
    results();
  end
endmodule // testbench
